// ---- core/bmp_ctrl.sv ----
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/10ps
// ==========================================================
module bmp_ctrl
   import bmp_pkg::*;
#(
   parameter int unsigned CNT_W         = 20,
   parameter int unsigned OVERLOAD_LIM  = OVERLOAD_CYC,
   parameter int unsigned MAX_ON_LIM    = MAX_ON_CYC,
   parameter int unsigned SOFTSTART_LIM = SOFTSTART_CYC,
   parameter int unsigned BURST_BLK_LIM = BURST_BLK_CYC,
   parameter int unsigned OVP_BLK_LIM   = OVP_BLK_CYC
) (
   input  wire logic              ref_clk_i,
   input  wire logic              nrst_i,
   input  wire bmp_cmp_s          cmp_i,
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [DATA_W-1:0] wdata_i,
   input  wire logic              wr_i,
   input  wire logic              rd_i,
   output logic      [DATA_W-1:0] rdata_o,
   output logic                   gate_o,
   output logic                   startup_on_o,
   output logic                   bias_on_o,
   output logic                   burst_o,
   output logic                   burst_limit_o,
   output logic                   soft_start_o,
   output logic                   valley_load_o,
   output logic      [2:0]        valley_load_val_o,
   output logic                   irq_o
);

   // ==========================================================
   // Limits at counter width, burst period at timer width
   // ==========================================================
   localparam logic [CNT_W-1:0] L_OVL = CNT_W'(OVERLOAD_LIM);
   localparam logic [CNT_W-1:0] L_MAX = CNT_W'(MAX_ON_LIM - 1);
   localparam logic [CNT_W-1:0] L_SS  = CNT_W'(SOFTSTART_LIM);
   localparam logic [CNT_W-1:0] L_BEB = CNT_W'(BURST_BLK_LIM);
   localparam logic [CNT_W-1:0] L_OVP = CNT_W'(OVP_BLK_LIM);
   localparam logic [CNT_W-1:0] L_HALF = CNT_W'(BURST_ON_CYC - 1);
   localparam logic [7:0]       L_PER  = 8'(BURST_PER_CYC - 1);

   // ==========================================================
   // Input synchronisation
   // ==========================================================
   bmp_cmp_s   s;
   bmp_state_e state_q, state_d;
   logic [CNT_W-1:0] on_cnt_q, ovl_cnt_q, ss_cnt_q, beb_cnt_q, ovp_cnt_q;
   logic [7:0]  tmr_q;
   logic        gate_q, startup_q, ctrl_burst_en_q;
   logic [EV_W-1:0] stat_q, mask_q, stat_d, mask_d, ev;
   logic        active, in_burst, in_burst_d, switching;
   logic        latch_fault, auto_fault, entry_ok, max_on_hit, tmr_wrap;
   logic        gate_end;

   bmp_sync #(
      .W ($bits(bmp_cmp_s))
   ) u_sync (
      .ref_clk_i (ref_clk_i),
      .nrst_i    (nrst_i),
      .d_i       (cmp_i),
      .q_o       (s)
   );

   // ==========================================================
   // Fault and mode decisions
   // ==========================================================
   assign active   = (state_q == ST_SOFTSTART) || (state_q == ST_NORMAL) ||
                     (state_q == ST_BURST_PAUSE) || (state_q == ST_BURST_RUN);
   assign in_burst = (state_q == ST_BURST_PAUSE) || (state_q == ST_BURST_RUN);
   assign in_burst_d = (state_d == ST_BURST_PAUSE) ||
                       (state_d == ST_BURST_RUN);
   assign max_on_hit = gate_q && (on_cnt_q == L_MAX);
   assign tmr_wrap   = (tmr_q == L_PER);
   assign latch_fault = active && ((ovp_cnt_q == L_OVP) ||
                                   (gate_q && s.cs_short));
   assign auto_fault  = active && (s.vcc_uv || s.vcc_ov || s.otp ||
                                   (ovl_cnt_q == L_OVL));
   assign entry_ok = s.fb_entry && (s.valley_cnt == VALLEY_ENTRY) &&
                     (beb_cnt_q == L_BEB) && ctrl_burst_en_q;

   // ==========================================================
   // Mode state machine
   // ==========================================================
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         ST_RESTART:
            if (startup_q && s.vcc_on)
               state_d = ST_SOFTSTART;
         ST_SOFTSTART:
            if (ss_cnt_q == L_SS)
               state_d = ST_NORMAL;
         ST_NORMAL:
            if (entry_ok)
               state_d = ST_BURST_PAUSE;
         ST_BURST_PAUSE:
            if (s.fb_exit)
               state_d = ST_NORMAL;
            else if (s.fb_upper)
               state_d = ST_BURST_RUN;
         ST_BURST_RUN:
            if (s.fb_exit)
               state_d = ST_NORMAL;
            else if (s.fb_lower)
               state_d = ST_BURST_PAUSE;
         ST_LATCH:
            if (s.vcc_release)
               state_d = ST_RESTART;
         default:
            state_d = ST_RESTART;
      endcase
      // Latch-off checked first so a coincident auto-restart cannot mask it
      if (latch_fault)
         state_d = ST_LATCH;
      else if (auto_fault)
         state_d = ST_RESTART;
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_i)
         state_q <= ST_RESTART;
      else
         state_q <= state_d;
   end

   // ==========================================================
   // Blanking and period counters
   // ==========================================================
   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_i || !active || !s.fb_overload)
         ovl_cnt_q <= '0;
      else if (ovl_cnt_q != L_OVL)
         ovl_cnt_q <= ovl_cnt_q + 1'b1;
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_i || !active || gate_q || !s.zc_ovp)
         ovp_cnt_q <= '0;
      else if (ovp_cnt_q != L_OVP)
         ovp_cnt_q <= ovp_cnt_q + 1'b1;
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_i || (state_q != ST_NORMAL) || !s.fb_entry ||
          (s.valley_cnt != VALLEY_ENTRY))
         beb_cnt_q <= '0;
      else if (beb_cnt_q != L_BEB)
         beb_cnt_q <= beb_cnt_q + 1'b1;
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_i || (state_q != ST_SOFTSTART))
         ss_cnt_q <= '0;
      else if (ss_cnt_q != L_SS)
         ss_cnt_q <= ss_cnt_q + 1'b1;
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_i || !gate_q)
         on_cnt_q <= '0;
      else if (on_cnt_q != L_MAX)
         on_cnt_q <= on_cnt_q + 1'b1;
   end

   // Free-running while in burst, independent of valley detection
   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_i || !in_burst || tmr_wrap)
         tmr_q <= '0;
      else
         tmr_q <= tmr_q + 1'b1;
   end

   // ==========================================================
   // Gate drive
   // ==========================================================
   assign switching = (state_d == state_q) && ((state_q == ST_SOFTSTART) ||
                      (state_q == ST_NORMAL) || (state_q == ST_BURST_RUN));
   assign gate_end  = max_on_hit || ((state_q == ST_BURST_RUN) ?
                      (s.cs_burst || (on_cnt_q == L_HALF)) :
                      s.cs_normal);

   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_i || !switching)
         gate_q <= 1'b0;
      else if (gate_q && gate_end)
         gate_q <= 1'b0;
      else if (!gate_q && ((state_q == ST_BURST_RUN) ? tmr_wrap : s.on_req))
         gate_q <= 1'b1;
   end

   assign gate_o = gate_q;

   // ==========================================================
   // Start-up cell
   // ==========================================================
   // Power-on begins with the cell charging the supply
   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_i)
         startup_q <= 1'b1;
      else if (active)
         startup_q <= 1'b0;
      else if (s.vcc_uv)
         startup_q <= 1'b1;
      else if (s.vcc_on)
         startup_q <= 1'b0;
   end

   assign startup_on_o = startup_q;

   // ==========================================================
   // Mode outputs
   // ==========================================================
   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_i)
      begin
         bias_on_o     <= 1'b0;
         burst_o       <= 1'b0;
         burst_limit_o <= 1'b0;
         soft_start_o  <= 1'b0;
      end
      else
      begin
         bias_on_o     <= (state_d == ST_SOFTSTART) ||
                          (state_d == ST_NORMAL) ||
                          (state_d == ST_BURST_RUN);
         burst_o       <= in_burst_d;
         burst_limit_o <= in_burst_d;
         soft_start_o  <= (state_d == ST_SOFTSTART);
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_i)
      begin
         valley_load_o     <= 1'b0;
         valley_load_val_o <= VALLEY_RESUME;
      end
      else
      begin
         valley_load_o     <= in_burst && (state_d == ST_NORMAL);
         valley_load_val_o <= VALLEY_RESUME;
      end
   end

   // ==========================================================
   // Register port and interrupts
   // ==========================================================
   assign ev[EV_BURST_IN]  = !in_burst && in_burst_d;
   assign ev[EV_BURST_OUT] = in_burst && !in_burst_d;
   assign ev[EV_RESTART]   = active && (state_d == ST_RESTART);
   assign ev[EV_LATCH]     = active && (state_d == ST_LATCH);
   assign ev[EV_MAX_ON]    = max_on_hit;

   // Set beats clear so no event is lost in the clearing cycle
   always_comb
   begin
      stat_d = stat_q;
      mask_d = mask_q;
      if (wr_i && (addr_i == OFS_IRQ_ST))
         stat_d = stat_q & ~wdata_i[EV_W-1:0];
      if (wr_i && (addr_i == OFS_IRQ_MSK))
         mask_d = wdata_i[EV_W-1:0];
      stat_d = stat_d | ev;
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_i)
      begin
         stat_q <= '0;
         mask_q <= MSK_RESET;
         irq_o  <= 1'b0;
      end
      else
      begin
         stat_q <= stat_d;
         mask_q <= mask_d;
         irq_o  <= |(stat_d & mask_d);
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_i)
         ctrl_burst_en_q <= CTRL_RESET;
      else if (wr_i && (addr_i == OFS_CTRL))
         ctrl_burst_en_q <= wdata_i[CTRL_BURST_EN];
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_i || !rd_i)
         rdata_o <= '0;
      else if (addr_i == OFS_CTRL)
         rdata_o <= DATA_W'(ctrl_burst_en_q);
      else if (addr_i == OFS_STATE)
         rdata_o <= DATA_W'({startup_q, gate_q, state_q});
      else if (addr_i == OFS_IRQ_ST)
         rdata_o <= DATA_W'(stat_q);
      else if (addr_i == OFS_IRQ_MSK)
         rdata_o <= DATA_W'(mask_q);
      else
         rdata_o <= '0;
   end

   // ==========================================================
   // Checks
   // ==========================================================
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!nrst_i);

   sequence s_enter_burst;
      !in_burst ##1 in_burst;
   endsequence

   sequence s_leave_burst;
      in_burst && s.fb_exit && !latch_fault && !auto_fault;
   endsequence

   chk_burst_entry_cond: assert property (
      s_enter_burst |-> $past(entry_ok))
      else $error("burst entered without all entry conditions");

   chk_burst_resume: assert property (
      (state_q == ST_BURST_PAUSE) && s.fb_upper && !s.fb_exit &&
      !latch_fault && !auto_fault |=> (state_q == ST_BURST_RUN) && bias_on_o)
      else $error("paused burst did not resume");

   chk_burst_duty: assert property (
      (state_q == ST_BURST_RUN) && gate_q |-> on_cnt_q <= L_HALF)
      else $error("burst pulse exceeded half period");

   chk_burst_pause: assert property (
      (state_q == ST_BURST_RUN) && s.fb_lower && !s.fb_exit &&
      !latch_fault && !auto_fault
      |=> (state_q == ST_BURST_PAUSE) && !gate_q ##1 !gate_q)
      else $error("burst did not pause at lower level");

   chk_valley_reload: assert property (
      s_leave_burst |=> valley_load_o && !burst_o && !burst_limit_o &&
      (valley_load_val_o == VALLEY_RESUME))
      else $error("valley counter not reloaded on burst exit");

   chk_supply_fault: assert property (
      active && (s.vcc_uv || s.vcc_ov) && !latch_fault
      |=> (state_q == ST_RESTART) && !gate_q)
      else $error("supply fault did not force auto-restart");

   chk_latch_hold: assert property (
      (state_q == ST_LATCH) && !s.vcc_release |=> (state_q == ST_LATCH) &&
      !gate_q)
      else $error("latch released without supply release");

   chk_latch_priority: assert property (
      latch_fault && auto_fault |=> state_q == ST_LATCH)
      else $error("auto-restart took priority over latch-off");

   chk_short_latch: assert property (
      active && gate_q && s.cs_short |=> (state_q == ST_LATCH) && !gate_q)
      else $error("short winding did not latch off");

   chk_max_on_time: assert property (
      gate_q && (on_cnt_q == L_MAX) |=> !gate_q)
      else $error("gate high beyond maximum on-time");

endmodule : bmp_ctrl

// ---- pkg/bmp_pkg.sv ----
package bmp_pkg;

   // ==========================================================
   // Clock and timing
   // ==========================================================
   localparam int unsigned CLK_HZ         = 10_000_000;
   localparam int unsigned T_OVERLOAD_MS  = 24;
   localparam int unsigned T_MAX_ON_MS    = 30;
   localparam int unsigned T_SOFTSTART_MS = 12;
   localparam int unsigned T_BURST_BLK_US = 500;
   localparam int unsigned T_OVP_BLK_US   = 5;
   localparam int unsigned F_BURST_HZ     = 52_000;
   localparam int unsigned DUTY_MAX_PCT   = 50;

   // Least times round up, longest times round down
   localparam int unsigned OVERLOAD_CYC  = T_OVERLOAD_MS * (CLK_HZ / 1000);
   localparam int unsigned MAX_ON_CYC    = T_MAX_ON_MS * (CLK_HZ / 1000);
   localparam int unsigned SOFTSTART_CYC = T_SOFTSTART_MS * (CLK_HZ / 1000);
   localparam int unsigned BURST_BLK_CYC =
      (T_BURST_BLK_US * (CLK_HZ / 1000) + 999) / 1000;
   localparam int unsigned OVP_BLK_CYC   =
      (T_OVP_BLK_US * (CLK_HZ / 1000) + 999) / 1000;
   localparam int unsigned BURST_PER_CYC = CLK_HZ / F_BURST_HZ;
   localparam int unsigned BURST_ON_CYC  = BURST_PER_CYC * DUTY_MAX_PCT / 100;

   // ==========================================================
   // Valley counter values
   // ==========================================================
   localparam logic [2:0] VALLEY_ENTRY  = 3'h7;
   localparam logic [2:0] VALLEY_RESUME = 3'h1;

   // ==========================================================
   // Register map
   // ==========================================================
   localparam int unsigned   ADDR_W      = 4;
   localparam int unsigned   DATA_W      = 32;
   localparam int unsigned   EV_W        = 5;
   localparam logic [3:0]    OFS_CTRL    = 4'h0;
   localparam logic [3:0]    OFS_STATE   = 4'h4;
   localparam logic [3:0]    OFS_IRQ_ST  = 4'h8;
   localparam logic [3:0]    OFS_IRQ_MSK = 4'hC;
   localparam int unsigned   CTRL_BURST_EN = 0;
   localparam logic          CTRL_RESET    = 1'h1;
   localparam logic [EV_W-1:0] MSK_RESET   = 5'h00;
   localparam int unsigned   EV_BURST_IN  = 0;
   localparam int unsigned   EV_BURST_OUT = 1;
   localparam int unsigned   EV_RESTART   = 2;
   localparam int unsigned   EV_LATCH     = 3;
   localparam int unsigned   EV_MAX_ON    = 4;

   // ==========================================================
   // Types
   // ==========================================================
   typedef enum logic [2:0] {
      ST_RESTART,
      ST_SOFTSTART,
      ST_NORMAL,
      ST_BURST_PAUSE,
      ST_BURST_RUN,
      ST_LATCH
   } bmp_state_e;

   typedef struct packed {
      logic [2:0] valley_cnt;
      logic       fb_entry;
      logic       fb_upper;
      logic       fb_lower;
      logic       fb_exit;
      logic       fb_overload;
      logic       cs_normal;
      logic       cs_burst;
      logic       cs_short;
      logic       zc_ovp;
      logic       vcc_uv;
      logic       vcc_ov;
      logic       vcc_on;
      logic       vcc_release;
      logic       otp;
      logic       on_req;
   } bmp_cmp_s;

endpackage : bmp_pkg

// ---- core/bmp_sync.sv ----
`timescale 1ns/10ps
module bmp_sync #(
   parameter int unsigned W = 8
) (
   input  wire logic         ref_clk_i,
   input  wire logic         nrst_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);

   // ==========================================================
   // Two-stage synchronisers, one per bit
   // ==========================================================
   logic [W-1:0] meta_q;

   for (genvar i = 0; i < W; i++)
   begin : g_bit
      always_ff @(posedge ref_clk_i)
      begin
         if (!nrst_i)
         begin
            meta_q[i] <= 1'b0;
            q_o[i]    <= 1'b0;
         end
         else
         begin
            meta_q[i] <= d_i[i];
            q_o[i]    <= meta_q[i];
         end
      end
   end

endmodule : bmp_sync

// ---- tb/bmp_stage_model.sv ----
`timescale 1ns/10ps
// ==========================================================
// Flyback stage: sense current ramps while the gate is high
// ==========================================================
module bmp_stage_model
   import bmp_pkg::*;
(
   input  wire logic       ref_clk_i,
   input  wire logic       gate_i,
   input  wire bmp_cmp_s   knob_i,
   input  wire logic [9:0] ramp_i,
   output bmp_cmp_s        cmp_o
);
   logic [9:0] cur_q;

   always_ff @(posedge ref_clk_i)
   begin
      if (!gate_i)
         cur_q <= 10'h000;
      else if (cur_q != 10'h3FF)
         cur_q <= cur_q + 10'h001;
   end

   // Sense lines only report in their own phase of the switch cycle
   always_comb
   begin
      cmp_o           = knob_i;
      cmp_o.cs_normal = gate_i && (cur_q >= ramp_i);
      cmp_o.cs_burst  = gate_i && knob_i.cs_burst && (cur_q >= 10'h028);
      cmp_o.cs_short  = gate_i && knob_i.cs_short;
      cmp_o.zc_ovp    = !gate_i && knob_i.zc_ovp;
   end
endmodule : bmp_stage_model

// ---- tb/tb_bmp_ctrl.sv ----
`timescale 1ns/10ps
module tb_bmp_ctrl
   import bmp_pkg::*;
;
   // ==========================================================
   // Bench signals
   // ==========================================================
   localparam int OVL = 50;
   logic              ref_clk_i = 1'b0;
   logic              nrst_i    = 1'b0;
   bmp_cmp_s          knob      = '0;
   bmp_cmp_s          cmp;
   logic [9:0]        ramp      = 10'h3E8;
   logic [ADDR_W-1:0] addr      = '0;
   logic [DATA_W-1:0] wdata     = '0;
   logic              wr        = 1'b0;
   logic              rd        = 1'b0;
   logic [DATA_W-1:0] rdata;
   logic              gate, startup, bias, burst, blim, ss, vload, irq;
   logic [2:0]        vval;
   int                num_errors = 0;
   int                checked    = 0;
   int                n, m;

   always #50 ref_clk_i = ~ref_clk_i;

   bmp_stage_model bmp_stage_model_inst (.ref_clk_i(ref_clk_i),
      .gate_i(gate), .knob_i(knob), .ramp_i(ramp), .cmp_o(cmp));

   bmp_ctrl #(.OVERLOAD_LIM(OVL), .MAX_ON_LIM(300), .SOFTSTART_LIM(20),
      .BURST_BLK_LIM(10), .OVP_BLK_LIM(4)) bmp_ctrl_inst (
      .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .cmp_i(cmp),
      .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
      .rdata_o(rdata), .gate_o(gate), .startup_on_o(startup),
      .bias_on_o(bias), .burst_o(burst), .burst_limit_o(blim),
      .soft_start_o(ss), .valley_load_o(vload),
      .valley_load_val_o(vval), .irq_o(irq));

   // ==========================================================
   // Access and compare tasks
   // ==========================================================
   task automatic step(input int k);
      repeat (k) @(negedge ref_clk_i);
   endtask : step

   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         num_errors++;
         $display("wrong value at %0t: got %0h expected %0h",
                  $time, got, exp);
      end
   endtask : chk_val

   task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
      @(posedge ref_clk_i);
      addr <= a;
      rd   <= 1'b1;
      @(posedge ref_clk_i);
      rd   <= 1'b0;
      @(negedge ref_clk_i);
      v = rdata;
   endtask : rd_reg

   task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
      @(posedge ref_clk_i);
      addr  <= a;
      wdata <= v;
      wr    <= 1'b1;
      @(posedge ref_clk_i);
      wr    <= 1'b0;
      step(1);
   endtask : wr_reg

   task automatic chk_reg(input logic [3:0] a, input logic [31:0] exp);
      logic [31:0] v;
      rd_reg(a, v);
      chk_val(v, exp);
   endtask : chk_reg

   task automatic chk_state(input bmp_state_e s);
      logic [31:0] v;
      rd_reg(OFS_STATE, v);
      chk_val({29'h0, v[2:0]}, {29'h0, s});
   endtask : chk_state

   function automatic logic pick(input int s);
      case (s)
         0:       return gate;
         1:       return bias;
         2:       return burst;
         3:       return vload;
         default: return ss;
      endcase
   endfunction : pick

   // Bounded so a stuck output cannot hang the run
   task automatic wait_sig(input int s, input logic lvl, output int k);
      k = 0;
      while (pick(s) !== lvl && k < 3000)
      begin
         step(1);
         k++;
      end
   endtask : wait_sig

   task automatic boot();
      @(posedge ref_clk_i);
      knob <= '0;
      @(posedge ref_clk_i);
      knob.vcc_uv <= 1'b1;
      step(5);
      chk_val(startup, 1);
      @(posedge ref_clk_i);
      knob.vcc_uv <= 1'b0;
      knob.vcc_on <= 1'b1;
      wait_sig(4, 1, n);
      chk_val(n < 6, 1);
      step(25);
      chk_state(ST_NORMAL);
   endtask : boot

   task automatic close_out();
      $display("checks %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : close_out

   // ==========================================================
   // Watchdog, over ten times the expected run
   // ==========================================================
   initial
   begin
      #2_000_000;
      num_errors++;
      close_out();
   end

   // ==========================================================
   // Test sequence
   // ==========================================================
   initial
   begin
      repeat (2) @(posedge ref_clk_i);
      nrst_i <= 1'b1;
      chk_reg(OFS_CTRL, 32'h1);
      chk_reg(OFS_STATE, 32'h10);
      chk_reg(OFS_IRQ_MSK, 32'h0);
      chk_reg(4'h2, 32'h0);
      boot();
      wr_reg(OFS_IRQ_ST, 32'h1F);
      chk_val(irq, 0);
      wr_reg(OFS_CTRL, 32'h0);
      chk_reg(OFS_CTRL, 32'h0);
      @(posedge ref_clk_i);
      knob.fb_entry   <= 1'b1;
      knob.valley_cnt <= VALLEY_ENTRY;
      step(30);
      chk_val(burst, 0);
      @(posedge ref_clk_i);
      knob.valley_cnt <= 3'h6;
      wr_reg(OFS_CTRL, 32'h1);
      step(30);
      chk_val(burst, 0);
      @(posedge ref_clk_i);
      knob.valley_cnt <= VALLEY_ENTRY;
      step(9);
      chk_val(burst, 0);
      wait_sig(2, 1, n);
      chk_val(n < 8, 1);
      chk_val(bias, 0);
      chk_val(irq, 0);
      wr_reg(OFS_IRQ_MSK, 32'h1F);
      chk_val(irq, 1);
      wr_reg(OFS_IRQ_MSK, 32'h0);
      chk_val(irq, 0);
      wr_reg(OFS_IRQ_MSK, 32'h1F);
      wr_reg(OFS_IRQ_ST, 32'h1);
      chk_val(irq, 0);
      @(posedge ref_clk_i);
      knob.fb_entry <= 1'b0;
      knob.fb_upper <= 1'b1;
      wait_sig(1, 1, n);
      chk_val(n < 6, 1);
      chk_state(ST_BURST_RUN);
      wait_sig(0, 1, n);
      wait_sig(0, 0, n);
      chk_val(n, BURST_ON_CYC);
      chk_val(blim, 1);
      wait_sig(0, 1, m);
      chk_val(n + m, BURST_PER_CYC);
      @(posedge ref_clk_i);
      knob.cs_burst <= 1'b1;
      wait_sig(0, 0, n);
      wait_sig(0, 1, n);
      wait_sig(0, 0, n);
      chk_val(n < BURST_ON_CYC, 1);
      @(posedge ref_clk_i);
      knob.fb_upper <= 1'b0;
      knob.fb_lower <= 1'b1;
      wait_sig(1, 0, n);
      chk_val(n < 6, 1);
      step(300);
      chk_val(gate, 0);
      @(posedge ref_clk_i);
      knob.fb_lower   <= 1'b0;
      knob.fb_exit    <= 1'b1;
      knob.valley_cnt <= 3'h0;
      wait_sig(3, 1, n);
      chk_val(n < 6, 1);
      chk_val(vval, VALLEY_RESUME);
      chk_val({burst, blim}, 0);
      step(1);
      chk_val(vload, 0);
      @(posedge ref_clk_i);
      knob.fb_exit <= 1'b0;
      knob.on_req  <= 1'b1;
      wait_sig(0, 1, n);
      wait_sig(0, 0, n);
      chk_val(n, 300);
      @(posedge ref_clk_i);
      knob.on_req      <= 1'b0;
      knob.fb_overload <= 1'b1;
      wait_sig(1, 0, n);
      chk_val(n >= OVL - 3 && n < OVL + 6, 1);
      boot();
      // Over-temperature, supply overvoltage, supply undervoltage
      for (int i = 0; i < 3; i++)
      begin
         @(posedge ref_clk_i);
         knob.otp    <= (i == 0);
         knob.vcc_ov <= (i == 1);
         knob.vcc_uv <= (i == 2);
         wait_sig(1, 0, n);
         chk_val(n < 6, 1);
         chk_val(gate, 0);
         boot();
      end
      @(posedge ref_clk_i);
      knob.zc_ovp <= 1'b1;
      step(10);
      chk_state(ST_LATCH);
      @(posedge ref_clk_i);
      knob.zc_ovp <= 1'b0;
      knob.vcc_on <= 1'b0;
      knob.vcc_uv <= 1'b1;
      knob.otp    <= 1'b1;
      step(5);
      chk_val(startup, 1);
      @(posedge ref_clk_i);
      knob.vcc_uv <= 1'b0;
      knob.vcc_on <= 1'b1;
      step(5);
      chk_val({startup, gate}, 0);
      chk_state(ST_LATCH);
      @(posedge ref_clk_i);
      knob.vcc_release <= 1'b1;
      step(5);
      chk_state(ST_RESTART);
      boot();
      @(posedge ref_clk_i);
      knob.on_req <= 1'b1;
      wait_sig(0, 1, n);
      @(posedge ref_clk_i);
      knob.on_req   <= 1'b0;
      knob.cs_short <= 1'b1;
      knob.otp      <= 1'b1;
      step(6);
      chk_val(gate, 0);
      chk_state(ST_LATCH);
      close_out();
   end
endmodule : tb_bmp_ctrl
